// *** core/ucb_cache_ctrl.sv ***
/*
 * ucb_cache_ctrl: four-way unified cache controller with line fill, push buffer,
 * store buffer and half-cache locking.
 * Assumes the core holds a request until it sees ack, and the bus controller
 * returns four consecutive longwords for a line read, wrapping from the first.
 */
`timescale 1ns/1ns

module ucb_cache_ctrl #(
	parameter int NSETS    = 16,
	parameter int SB_DEPTH = ucb_pkg::SB_ENTRIES
) (
	input  wire logic                          clk,                     // processor clock
	input  wire logic                          rst_n,                   // async reset, low
	input  wire ucb_pkg::ucb_core_req_t        core_req,                // core access request
	output ucb_pkg::ucb_core_rsp_t             core_rsp,                // ack, fault, read data
	output ucb_pkg::ucb_bus_req_t              bus_req,                 // to bus controller
	input  wire ucb_pkg::ucb_bus_rsp_t         bus_rsp,                 // from bus controller
	input  wire logic                          store_buffer_enable_bit, // defer write-through and imprecise writes
	input  wire logic                          half_lock_bit,           // lock ways 0 and 1
	output logic                               push_pending,            // push buffer holds a line
	output logic [$clog2(SB_DEPTH):0]          sb_level                 // store buffer entries used
);
	import ucb_pkg::*;

	localparam int SET_W = $clog2(NSETS);
	localparam int TAG_W = 32 - 4 - SET_W;
	localparam int SBP_W = $clog2(SB_DEPTH);

	typedef struct packed {
		ucb_cst_t                                     cst;
		ucb_kind_t                                    kind;
		ucb_core_rsp_t                                core_rsp;
		ucb_bus_req_t                                 bus_req;
		ucb_core_req_t                                lreq;
		logic [1:0]                                   beat;
		logic [1:0]                                   fway;
		logic [1:0]                                   rr;
		logic [NSETS-1:0][WAYS-1:0]                   v;
		logic [NSETS-1:0][WAYS-1:0]                   m;
		logic [NSETS-1:0][WAYS-1:0][TAG_W-1:0]        tag;
		logic [NSETS-1:0][WAYS-1:0][LINE_WORDS-1:0][31:0] data;
		logic                                         pb_valid;
		logic                                         pb_hold;
		logic [31:0]                                  pb_addr;
		logic [LINE_WORDS-1:0][31:0]                  pb_data;
		logic [SB_DEPTH-1:0][$bits(ucb_sb_ent_t)-1:0] sb;
		logic [SBP_W-1:0]                             sb_rd;
		logic [SBP_W-1:0]                             sb_wr;
		logic [SBP_W:0]                               sb_cnt;
		logic [31:0]                                  sp_addr;
		logic [2:0]                                   sp_rem;
		logic [31:0]                                  sp_data;
	} ucb_state_t;

	ucb_state_t s;
	ucb_state_t n;

	function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
		return SET_W'(a >> 4);
	endfunction

	function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
		return TAG_W'(a >> (4 + SET_W));
	endfunction

	function automatic logic [2:0] nbytes(input logic [1:0] sz);
		return (sz == SZ_BYTE) ? 3'h1 : (sz == SZ_WORD) ? 3'h2 : 3'h4;
	endfunction

	// bytes in the next bus cycle: largest naturally aligned piece that fits
	function automatic logic [2:0] pbytes(input logic [31:0] a, input logic [2:0] rem);
		if (rem >= 3'h4 && a[1:0] == 2'h0)
			return 3'h4;
		else if (rem >= 3'h2 && !a[0])
			return 3'h2;
		return 3'h1;
	endfunction

	// one bus cycle worth of a write; data is right-justified, high bytes go first
	function automatic ucb_sb_ent_t piece(input logic [31:0] a, input logic [2:0] rem,
			input logic [31:0] d);
		ucb_sb_ent_t p;
		logic [2:0]  k;
		logic [31:0] sh;
		k = pbytes(a, rem);
		sh = d >> (8 * (int'(rem) - int'(k)));
		p.addr = a;
		p.size = (k == 3'h4) ? SZ_LONG : (k == 3'h2) ? SZ_WORD : SZ_BYTE;
		p.data = (k == 3'h4) ? sh : (k == 3'h2) ? {16'h0000, sh[15:0]} : {24'h000000, sh[7:0]};
		return p;
	endfunction

	// merge write bytes into a big-endian longword; bytes past it are dropped
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] a,
			input logic [1:0] sz, input logic [31:0] wd);
		logic [31:0] r;
		int          nb;
		int          o;
		r = old;
		nb = int'(nbytes(sz));
		for (int i = 0; i < 4; i++) begin
			o = int'(a[1:0]) + i;
			if (i < nb && o < 4)
				r[8*(3-o) +: 8] = wd[8*(nb-1-i) +: 8];
		end
		return r;
	endfunction

	// victim choice; unlocked uses all ways, locked only ways 2 and 3
	function automatic logic [1:0] victim(input logic [WAYS-1:0] vv, input logic lock,
			input logic [1:0] rr);
		if (lock) begin
			if (!vv[LOCK_WAY_A])
				return 2'(LOCK_WAY_A);
			if (!vv[LOCK_WAY_B])
				return 2'(LOCK_WAY_B);
			return rr[1] ? 2'(LOCK_WAY_B) : 2'(LOCK_WAY_A);
		end
		for (int w = 0; w < WAYS; w++)
			if (!vv[w])
				return 2'(w);
		return rr;
	endfunction

	logic [SET_W-1:0] cset;
	logic [SET_W-1:0] lset;
	logic             hit;
	logic [1:0]       hway;
	logic [1:0]       wi;
	logic [1:0]       vw;
	logic [2:0]       k;
	logic             idle_all;
	logic             cacheable;
	logic             use_sb;
	logic             sb_push;
	logic             sb_pop;
	ucb_sb_ent_t      pc;
	ucb_sb_ent_t      sbh;

	// whole controller: bus engine first, then the core-facing sequencer
	always_comb begin
		n = s;
		n.core_rsp.ack = 1'b0;
		n.core_rsp.fault = 1'b0;
		sb_push = 1'b0;
		sb_pop = 1'b0;
		cset = set_of(core_req.addr);
		lset = set_of(s.lreq.addr);
		hit = 1'b0;
		hway = 2'h0;
		for (int w = 0; w < WAYS; w++)
			if (s.v[cset][w] && s.tag[cset][w] == tag_of(core_req.addr)) begin
				hit = 1'b1;
				hway = 2'(w);
			end
		wi = s.lreq.addr[3:2] + s.beat;
		vw = victim(s.v[lset], half_lock_bit, s.rr);
		k = pbytes(s.sp_addr, s.sp_rem);
		pc = piece(s.sp_addr, s.sp_rem, s.sp_data);
		sbh = ucb_sb_ent_t'(s.sb[s.sb_rd]);
		idle_all = !s.bus_req.valid && !s.pb_valid && s.sb_cnt == '0;
		cacheable = (s.lreq.mode == MODE_COPYBACK) || (s.lreq.mode == MODE_WTHRU);
		use_sb = store_buffer_enable_bit && (core_req.mode == MODE_WTHRU ||
			core_req.mode == MODE_INH_IMPRECISE);

		// bus engine; no snoop input exists, other masters never reach the arrays
		if (s.bus_req.valid) begin
			if (bus_rsp.err) begin
				// abort mid-burst and raise the fault the same edge
				n.bus_req.valid = 1'b0;
				n.core_rsp.fault = 1'b1;
				n.beat = 2'h0;
				if (s.kind == K_PUSH)
					n.pb_valid = 1'b0;
				if (s.kind == K_SB)
					sb_pop = 1'b1;
				if (s.kind == K_FILL || s.kind == K_DIR) begin
					n.cst = C_IDLE;
					n.pb_hold = 1'b0;
				end
			end else if (bus_rsp.ack) begin
				unique case (s.kind)
					K_FILL: begin
						n.data[lset][s.fway][wi] = bus_rsp.rdata;
						n.beat = s.beat + 2'h1;
						if (s.beat == 2'h0 && !s.lreq.we) begin
							n.core_rsp.rdata = bus_rsp.rdata;       // critical word first
							n.core_rsp.ack = 1'b1;
						end
						if (s.beat == 2'(LINE_WORDS - 1)) begin
							n.bus_req.valid = 1'b0;
							n.v[lset][s.fway] = 1'b1;
							n.tag[lset][s.fway] = tag_of(s.lreq.addr);
							n.pb_hold = 1'b0;                        // victim may go now
							n.cst = C_IDLE;
							if (s.lreq.we) begin
								n.data[lset][s.fway][s.lreq.addr[3:2]] = merge(
									s.data[lset][s.fway][s.lreq.addr[3:2]], s.lreq.addr,
									s.lreq.size, s.lreq.wdata);
								n.m[lset][s.fway] = 1'b1;
								n.core_rsp.ack = 1'b1;
							end
						end
					end
					K_PUSH: begin
						n.beat = s.beat + 2'h1;
						n.bus_req.wdata = s.pb_data[s.beat + 2'h1];
						if (s.beat == 2'(LINE_WORDS - 1)) begin
							n.bus_req.valid = 1'b0;
							n.pb_valid = 1'b0;
						end
					end
					K_SB: begin
						n.bus_req.valid = 1'b0;
						sb_pop = 1'b1;
					end
					K_DIR: begin
						if (s.lreq.we && s.sp_rem != 3'h0) begin
							// next piece of a split unbuffered write
							n.bus_req.addr = pc.addr;
							n.bus_req.size = pc.size;
							n.bus_req.wdata = pc.data;
							n.sp_addr = s.sp_addr + 32'(k);
							n.sp_rem = s.sp_rem - k;
						end else begin
							n.bus_req.valid = 1'b0;
							n.core_rsp.rdata = bus_rsp.rdata;
							n.core_rsp.ack = 1'b1;                   // held until termination
							n.cst = C_IDLE;
						end
					end
				endcase
			end
		end else if (s.pb_valid && !s.pb_hold) begin
			// free bus cycle: push buffer goes out as a line write
			n.bus_req = '{valid: 1'b1, we: 1'b1, size: SZ_LINE, addr: s.pb_addr,
				wdata: s.pb_data[0]};
			n.kind = K_PUSH;
			n.beat = 2'h0;
		end else if (s.sb_cnt != '0) begin
			n.bus_req = '{valid: 1'b1, we: 1'b1, size: sbh.size, addr: sbh.addr,
				wdata: sbh.data};
			n.kind = K_SB;
		end

		// core-facing sequencer
		unique case (s.cst)
			C_IDLE: begin
				// a fault ends the access like an ack, so the held request is not taken twice
				if (core_req.valid && !s.core_rsp.ack && !s.core_rsp.fault) begin
					n.lreq = core_req;
					if (core_req.op == OP_SYNC) begin
						if (idle_all)
							n.core_rsp.ack = 1'b1;
					end else if (core_req.op == OP_PUSH) begin
						if (!(s.v[cset][core_req.wdata[1:0]] && s.m[cset][core_req.wdata[1:0]])) begin
							n.v[cset][core_req.wdata[1:0]] = 1'b0;
							n.core_rsp.ack = 1'b1;
						end else if (!s.pb_valid) begin
							// explicit push of a modified line, also for locked ways
							n.pb_valid = 1'b1;
							n.pb_hold = 1'b0;
							n.pb_addr = {s.tag[cset][core_req.wdata[1:0]], cset, 4'h0};
							n.pb_data = s.data[cset][core_req.wdata[1:0]];
							n.v[cset][core_req.wdata[1:0]] = 1'b0;
							n.m[cset][core_req.wdata[1:0]] = 1'b0;
							n.core_rsp.ack = 1'b1;
						end
					end else if (!core_req.we) begin
						if (core_req.mode <= MODE_WTHRU && hit) begin
							n.core_rsp.rdata = s.data[cset][hway][core_req.addr[3:2]];
							n.core_rsp.ack = 1'b1;                   // no state change
						end else
							n.cst = C_WAIT;
					end else begin
						if (core_req.mode <= MODE_WTHRU && hit)
							n.data[cset][hway][core_req.addr[3:2]] = merge(
								s.data[cset][hway][core_req.addr[3:2]], core_req.addr,
								core_req.size, core_req.wdata);
						n.sp_addr = core_req.addr;
						n.sp_rem = nbytes(core_req.size);
						n.sp_data = core_req.wdata;
						if (core_req.mode == MODE_COPYBACK) begin
							if (hit) begin
								n.m[cset][hway] = 1'b1;              // no bus write
								n.core_rsp.ack = 1'b1;
							end else
								n.cst = C_WAIT;
						end else if (use_sb)
							n.cst = C_SPLIT;
						else
							n.cst = C_WAIT;
					end
				end
			end
			C_WAIT: begin
				// fills and unbuffered cycles only start on an empty pipe
				if (idle_all) begin
					if (cacheable && (!s.lreq.we || s.lreq.mode == MODE_COPYBACK)) begin
						if (s.v[lset][vw] && s.m[lset][vw]) begin
							n.pb_valid = 1'b1;                       // held behind the fill
							n.pb_hold = 1'b1;
							n.pb_addr = {s.tag[lset][vw], lset, 4'h0};
							n.pb_data = s.data[lset][vw];
						end
						if (half_lock_bit ? (s.v[lset][LOCK_WAY_A] && s.v[lset][LOCK_WAY_B])
								: (&s.v[lset]))
							n.rr = half_lock_bit ? (s.rr ^ 2'h2) : (s.rr + 2'h1);
						n.v[lset][vw] = 1'b0;
						n.m[lset][vw] = 1'b0;
						n.fway = vw;
						n.beat = 2'h0;
						n.kind = K_FILL;
						n.bus_req = '{valid: 1'b1, we: 1'b0, size: SZ_LINE,
							addr: {s.lreq.addr[31:2], 2'h0}, wdata: 32'h00000000};
						n.cst = C_FILL;
					end else begin
						n.kind = K_DIR;
						n.cst = C_DIR;
						if (s.lreq.we) begin
							n.bus_req = '{valid: 1'b1, we: 1'b1, size: pc.size, addr: pc.addr,
								wdata: pc.data};
							n.sp_addr = s.sp_addr + 32'(k);
							n.sp_rem = s.sp_rem - k;
						end else
							n.bus_req = '{valid: 1'b1, we: 1'b0, size: s.lreq.size,
								addr: s.lreq.addr, wdata: 32'h00000000};
					end
				end
			end
			C_SPLIT: begin
				// one entry per clock; core held only while the buffer is full
				if (s.sb_cnt != (SBP_W + 1)'(SB_DEPTH)) begin
					sb_push = 1'b1;
					n.sb[s.sb_wr] = pc;
					n.sb_wr = s.sb_wr + 1'b1;
					n.sp_addr = s.sp_addr + 32'(k);
					n.sp_rem = s.sp_rem - k;
					if (s.sp_rem == k) begin
						n.core_rsp.ack = 1'b1;
						n.cst = C_IDLE;
					end
				end
			end
			C_FILL, C_DIR: begin
				// waiting for the bus engine to finish
			end
			default: n.cst = C_IDLE;
		endcase

		if (sb_pop)
			n.sb_rd = s.sb_rd + 1'b1;
		n.sb_cnt = s.sb_cnt + (SBP_W + 1)'(sb_push) - (SBP_W + 1)'(sb_pop);
	end

	// reset clears buffers, flags and the enable-driven paths; arrays restart empty
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign core_rsp = s.core_rsp;
	assign bus_req = s.bus_req;
	assign push_pending = s.pb_valid;
	assign sb_level = s.sb_cnt;

endmodule

// *** core/ucb_pkg.sv ***
/*
 * ucb_pkg: shared constants and carrier types for the unified cache controller.
 * Assumes one processor clock; the bus controller on the far side answers with
 * per-longword acknowledges and a single error strobe.
 */
package ucb_pkg;

	// cache geometry and buffer sizes
	localparam int WAYS       = 4;
	localparam int LINE_WORDS = 4;
	localparam int SB_ENTRIES = 4;   // store buffer entries, 4 bytes each
	localparam int PB_BYTES   = 16;  // push buffer holds one line
	localparam int LOCK_WAY_A = 2;   // first way allocated while half-locked
	localparam int LOCK_WAY_B = 3;

	// transfer size code on the bus
	localparam logic [1:0] SZ_LONG = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_LINE = 2'h3;

	// region cache mode given with each access
	localparam logic [1:0] MODE_COPYBACK     = 2'h0;
	localparam logic [1:0] MODE_WTHRU        = 2'h1;
	localparam logic [1:0] MODE_INH_PRECISE  = 2'h2;
	localparam logic [1:0] MODE_INH_IMPRECISE = 2'h3;

	// core request kinds
	localparam logic [1:0] OP_ACCESS = 2'h0;
	localparam logic [1:0] OP_SYNC   = 2'h1;  // supervisor op, no-op or exception entry
	localparam logic [1:0] OP_PUSH   = 2'h2;  // line push instruction

	typedef enum logic [2:0] {
		C_IDLE  = 3'b000,
		C_WAIT  = 3'b001,
		C_FILL  = 3'b010,
		C_SPLIT = 3'b011,
		C_DIR   = 3'b100
	} ucb_cst_t;

	typedef enum logic [1:0] {
		K_FILL = 2'b00,
		K_PUSH = 2'b01,
		K_SB   = 2'b10,
		K_DIR  = 2'b11
	} ucb_kind_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [1:0]  op;
		logic [1:0]  mode;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ucb_core_req_t;

	typedef struct packed {
		logic        ack;
		logic        fault;
		logic [31:0] rdata;
	} ucb_core_rsp_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ucb_bus_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} ucb_bus_rsp_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0]  size;
		logic [31:0] data;
	} ucb_sb_ent_t;

endpackage

// *** verif/ucb_bus_model.sv ***
/* ucb_bus_model: behavioural bus controller and memory at the far side.
   Assumes one transfer at a time, fields held between acks; logs every write beat and the first beat of each read. */
`timescale 1ns/1ns
module ucb_bus_model (
	input  wire logic                  clk,      // processor clock
	input  wire logic                  rst_n,    // async reset, low
	input  wire ucb_pkg::ucb_bus_req_t bus_req,  // request from controller
	output ucb_pkg::ucb_bus_rsp_t      bus_rsp,  // beat answers
	input  wire logic                  err_next, // answer next beat with an error
	input  wire logic [3:0]            slow      // most wait cycles per beat
);
	import ucb_pkg::*;
	logic [31:0] wa[$];
	logic [31:0] wd[$];
	logic [1:0]  ws[$];
	logic [31:0] ra[$];
	logic [31:0] a0;
	logic [31:0] ba;
	logic [1:0]  beat;
	logic [3:0]  wait_c;
	function automatic logic [31:0] mem_word(input logic [31:0] a);
		return a ^ 32'h5A5A_0000;
	endfunction
	// beat address wraps inside the line, starting at the first beat's longword
	always_comb begin
		ba = (beat == 2'h0) ? bus_req.addr : a0;
		ba = {ba[31:4], ba[3:2] + beat, 2'h0};
	end
	// idle data lines toggle so that a stale value can never pass for data
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rsp <= '0;
			beat <= 2'h0;
			wait_c <= 4'h0;
		end else begin
			bus_rsp.ack <= 1'b0;
			bus_rsp.err <= 1'b0;
			bus_rsp.rdata <= ~bus_rsp.rdata;
			if (!bus_req.valid) begin
				beat <= 2'h0;
			end else if (!bus_rsp.ack && !bus_rsp.err) begin
				if (wait_c != 4'h0) begin
					wait_c <= wait_c - 4'h1;
				end else if (err_next) begin
					bus_rsp.err <= 1'b1;
				end else begin
					bus_rsp.ack <= 1'b1;
					wait_c <= 4'($urandom_range(slow));
					if (beat == 2'h0) a0 <= bus_req.addr;
					if (bus_req.size == SZ_LINE) beat <= beat + 2'h1; // four longwords
					if (bus_req.we) begin
						wa.push_back(bus_req.size == SZ_LINE ? ba : bus_req.addr);
						wd.push_back(bus_req.wdata);
						ws.push_back(bus_req.size);
					end else begin
						if (beat == 2'h0) ra.push_back(bus_req.addr);
						bus_rsp.rdata <= mem_word(ba); // consecutive longwords
					end
				end
			end
		end
	end
endmodule

// *** verif/ucb_cache_ctrl_asserts.sv ***
/* ucb_cache_ctrl_asserts: port-level checks of the cache controller.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
module ucb_cache_ctrl_asserts #(
	parameter int SB_DEPTH = ucb_pkg::SB_ENTRIES
) (
	input wire logic                  clk,                     // processor clock
	input wire logic                  rst_n,                   // async reset, low
	input wire ucb_pkg::ucb_core_req_t core_req,               // core request
	input wire ucb_pkg::ucb_core_rsp_t core_rsp,               // core answer
	input wire ucb_pkg::ucb_bus_req_t bus_req,                 // bus request
	input wire ucb_pkg::ucb_bus_rsp_t bus_rsp,                 // bus answer
	input wire logic                  store_buffer_enable_bit, // buffer enable
	input wire logic                  half_lock_bit,           // half lock
	input wire logic                  push_pending,            // push buffer busy
	input wire logic [$clog2(SB_DEPTH):0] sb_level             // buffer occupancy
);
	import ucb_pkg::*;
	logic [2:0] beats_q;
	logic [2:0] beats_d;
	// beats acked so far in the current transfer
	always_comb begin
		beats_d = beats_q;
		if (!bus_req.valid) beats_d = 3'h0;
		else if (bus_rsp.ack) beats_d = beats_q + 3'h1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) beats_q <= 3'h0;
		else beats_q <= beats_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	line_end_a: assert property (
		bus_req.valid && bus_req.size == SZ_LINE && bus_rsp.ack && beats_q == 3'h3
		|=> !bus_req.valid) else $error("line transfer longer than four beats");
	line_early_a: assert property (
		bus_req.valid && bus_req.size == SZ_LINE && bus_rsp.ack && beats_q < 3'h3
		|=> bus_req.valid) else $error("line transfer ended before four beats");
	bus_hold_a: assert property (
		bus_req.valid && !bus_rsp.ack && !bus_rsp.err |=> bus_req.valid && $stable(bus_req))
		else $error("bus request changed before its answer");
	err_abort_a: assert property (
		bus_req.valid && bus_rsp.err |=> !bus_req.valid ##[0:2] core_rsp.fault)
		else $error("bus error did not abort and fault");
	ack_pulse_a: assert property (
		core_rsp.ack |=> !core_rsp.ack) else $error("core ack longer than one cycle");
	sync_drained_a: assert property (
		core_rsp.ack && core_req.valid && core_req.op == OP_SYNC
		|-> sb_level == '0 && !push_pending && !bus_req.valid)
		else $error("sync acknowledged with buffers busy");
	fill_drained_a: assert property (
		$rose(bus_req.valid) && !bus_req.we && bus_req.size == SZ_LINE |-> sb_level == '0)
		else $error("line fill started with stores queued");
	sb_bound_a: assert property (
		sb_level <= SB_DEPTH) else $error("store buffer over its depth");
	sb_nostall_a: assert property (
		$rose(core_req.valid) && core_req.we && store_buffer_enable_bit
		&& core_req.mode == MODE_INH_IMPRECISE && core_req.size == SZ_LONG
		&& core_req.addr[1:0] == 2'h0 && sb_level == '0 && !push_pending && !bus_req.valid
		|-> ##[1:3] core_rsp.ack) else $error("buffered write stalled with room");
	sb_drain_a: assert property (
		sb_level != '0 && !push_pending && !bus_req.valid |-> ##[1:3] bus_req.valid)
		else $error("queued store not sent on a free bus cycle");
	cover property (bus_req.valid && !bus_req.we && bus_req.size == SZ_LINE && bus_rsp.ack);
	cover property (bus_req.valid && bus_req.we && bus_req.size == SZ_LINE && bus_rsp.ack);
	cover property (core_rsp.fault);
endmodule

bind ucb_cache_ctrl ucb_cache_ctrl_asserts #(.SB_DEPTH(SB_DEPTH)) u_asserts (
	.clk(clk), .rst_n(rst_n), .core_req(core_req), .core_rsp(core_rsp),
	.bus_req(bus_req), .bus_rsp(bus_rsp), .store_buffer_enable_bit(store_buffer_enable_bit),
	.half_lock_bit(half_lock_bit), .push_pending(push_pending), .sb_level(sb_level)
);

// *** verif/ucb_cache_ctrl_test.sv ***
/* ucb_cache_ctrl_test: self-checking bench for the cache controller.
   Assumes the bus model answers with random waits and logs every write beat and the first beat of each read. */
`timescale 1ns/1ns
module ucb_cache_ctrl_test;
	import ucb_pkg::*;
	logic          clk;
	logic          rst_n;
	ucb_core_req_t req;
	ucb_core_rsp_t rsp;
	ucb_bus_req_t  breq;
	ucb_bus_rsp_t  brsp;
	logic          store_buffer_enable_bit;
	logic          half_lock_bit;
	logic          push_pending;
	logic [2:0]    sb_level;
	logic          err_next;
	logic [3:0]    slow;
	logic          flt;
	logic [31:0]   a, b, c, x1, x2, rd;
	int            n_errors;
	int            cmp_count;
	int            nw;
	ucb_cache_ctrl dut (
		.clk(clk), .rst_n(rst_n), .core_req(req), .core_rsp(rsp), .bus_req(breq),
		.bus_rsp(brsp), .store_buffer_enable_bit(store_buffer_enable_bit),
		.half_lock_bit(half_lock_bit),
		.push_pending(push_pending), .sb_level(sb_level));
	ucb_bus_model model (
		.clk(clk), .rst_n(rst_n), .bus_req(breq), .bus_rsp(brsp), .err_next(err_next),
		.slow(slow));
	function automatic logic [31:0] mem_word(input logic [31:0] ad);
		return ad ^ 32'h5A5A_0000;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// request held until ack or fault, released on the edge that samples it
	task automatic access(input logic w, input logic [1:0] op, input logic [1:0] md,
			input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] wdat);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, w, op, md, sz, ad, wdat};
		do begin
			@(posedge clk);
			n++;
		end while (rsp.ack !== 1'b1 && rsp.fault !== 1'b1 && n < 600);
		flt = rsp.fault;
		rd = rsp.rdata;
		req <= '0;
		if (n >= 600) n_errors++;
	endtask
	// bounded wait until bus and both buffers are idle
	task automatic drain();
		int n;
		n = 0;
		while ((push_pending !== 1'b0 || breq.valid !== 1'b0 || sb_level !== 3'h0) && n < 600) begin
			@(posedge clk);
			n++;
		end
		if (n >= 600) n_errors++;
	endtask
	task automatic rd_chk(input logic [31:0] ad, input logic [31:0] exp, input int fills);
		int f0;
		drain();
		f0 = model.ra.size();
		access(1'b0, OP_ACCESS, MODE_COPYBACK, SZ_LONG, ad, 32'h0);
		check(rd, exp);
		check(32'(model.ra.size() - f0), 32'(fills));
	endtask
	task automatic wr_chk(input logic [1:0] md, input logic [1:0] sz, input logic [31:0] ad,
			input logic [31:0] wdat, input int nexp);
		int w0;
		drain();
		w0 = model.wa.size();
		access(1'b1, OP_ACCESS, md, sz, ad, wdat);
		drain();
		check(32'(model.wa.size() - w0), 32'(nexp));
		if (nexp == 1) check(model.wd[w0], wdat);
	endtask
	// explicit push of one way: four line beats from the base, one word merged
	task automatic push_chk(input logic [31:0] ad, input logic [1:0] way, input logic [31:0] v);
		int w0;
		logic [31:0] la;
		drain();
		w0 = model.wa.size();
		access(1'b0, OP_PUSH, MODE_COPYBACK, SZ_LONG, ad, {30'h0, way});
		drain();
		check(32'(model.wa.size() - w0), 32'h4);
		for (int i = 0; i < 4; i++) begin
			la = {ad[31:4], i[1:0], 2'h0};
			check(model.wa[w0 + i], la);
			check(model.wd[w0 + i], (la[3:2] == ad[3:2]) ? v : mem_word(la));
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		req = '0;
		store_buffer_enable_bit = 1'b0;
		half_lock_bit = 1'b0;
		err_next = 1'b0;
		slow = 4'h3;
		n_errors = 0;
		cmp_count = 0;
		void'($urandom(90));
		a = $urandom & 32'h0FFF_FFF0;
		a[3:2] = 2'h1;
		x1 = $urandom;
		x2 = $urandom;
		b = a ^ 32'h0010_0000;
		c = a ^ 32'h0020_0000;
		repeat (2) @(posedge clk);
		check({27'h0, breq.valid, push_pending, sb_level}, 32'h0);
		rst_n <= 1'b1;
		// copyback write miss on an empty cache lands in way 0, modified
		wr_chk(MODE_COPYBACK, SZ_LONG, a, x1, 0);
		check(model.ra[0], a);
		rd_chk(a, x1, 0);
		rd_chk(a ^ 32'h4, mem_word(a ^ 32'h4), 0);
		push_chk(a, 2'h0, x1);
		rd_chk(a, mem_word(a), 1);
		wr_chk(MODE_WTHRU, SZ_LONG, a, x2, 1);
		wr_chk(MODE_WTHRU, SZ_BYTE, a + 32'h1, 32'hC3, 1);
		rd_chk(a, {x2[31:24], 8'hC3, x2[15:0]}, 0);
		wr_chk(MODE_WTHRU, SZ_LONG, b, x1, 1);
		rd_chk(b, mem_word(b), 1);
		wr_chk(MODE_COPYBACK, SZ_LONG, b, x2, 0);
		// half lock: new line goes to way 2, ways 0 and 1 keep their lines
		half_lock_bit <= 1'b1;
		wr_chk(MODE_COPYBACK, SZ_LONG, c, x1, 0);
		rd_chk(a, {x2[31:24], 8'hC3, x2[15:0]}, 0);
		push_chk(c, 2'h2, x1);
		push_chk(b, 2'h1, x2);
		// five buffered writes against a slow bus, then a sync
		half_lock_bit <= 1'b0;
		store_buffer_enable_bit <= 1'b1;
		slow <= 4'h6;
		drain();
		nw = model.wa.size();
		for (int i = 0; i < 5; i++) begin
			access(1'b1, OP_ACCESS, MODE_INH_IMPRECISE, SZ_LONG, b + 32'(i * 16), x1 + 32'(i));
		end
		access(1'b0, OP_SYNC, MODE_COPYBACK, SZ_LONG, 32'h0, 32'h0);
		check(32'(model.wa.size() - nw), 32'h5);
		for (int i = 0; i < 5; i++) check(model.wd[nw + i], x1 + 32'(i));
		nw = model.wa.size();
		access(1'b1, OP_ACCESS, MODE_INH_IMPRECISE, SZ_LONG, a + 32'h1, x2);
		drain();
		check(32'({model.ws[nw], model.ws[nw + 1], model.ws[nw + 2]}), 32'h19);
		nw = model.wa.size();
		access(1'b1, OP_ACCESS, MODE_INH_PRECISE, SZ_LONG, b, x2);
		check(32'(model.wa.size() - nw), 32'h1);
		// bus error on a fill aborts it and leaves the line invalid
		store_buffer_enable_bit <= 1'b0;
		err_next <= 1'b1;
		drain();
		access(1'b0, OP_ACCESS, MODE_COPYBACK, SZ_LONG, c, 32'h0);
		check(32'(flt), 32'h1);
		err_next <= 1'b0;
		rd_chk(c, mem_word(c), 1);
		// all four ways full; the round-robin victim is way 0, made dirty first
		wr_chk(MODE_COPYBACK, SZ_LONG, a, x1, 0);
		rd_chk(a ^ 32'h0040_0000, mem_word(a ^ 32'h0040_0000), 1);
		rd_chk(a ^ 32'h0080_0000, mem_word(a ^ 32'h0080_0000), 1);
		nw = model.wa.size();
		access(1'b1, OP_ACCESS, MODE_COPYBACK, SZ_LONG, a ^ 32'h00C0_0000, x2);
		check(32'(model.wa.size() - nw), 32'h0);
		check(32'(push_pending), 32'h1);
		drain();
		for (int i = 0; i < 4; i++) check(model.wa[nw + i], {a[31:4], 2'(i), 2'h0});
		check(model.wd[nw + 1], x1);
		rd_chk(a, mem_word(a), 1);
		give_verdict();
	end
endmodule
